/* File: verilog/debug_status_defines.vh */
// Constants for the debug status register bank.
// Assumes it is included by its bare name from the bank's design file.
`ifndef DEBUG_STATUS_DEFINES_VH
`define DEBUG_STATUS_DEFINES_VH

// Register numbers on the processor-status port.
`define REG_TILE_CELL_OSC 8'h07
`define REG_TILE_WIRE_OSC 8'h08
`define REG_PERIPH_CELL_OSC 8'h09
`define REG_PERIPH_WIRE_OSC 8'h0A
`define REG_MEMORY_SIZE 8'h0C
`define REG_SAVED_STATUS 8'h10
`define REG_SAVED_COUNTER 8'h11
`define REG_SAVED_STACK 8'h12
`define REG_FETCH_THREAD 8'h13
`define REG_FETCH_REGISTER 8'h14
`define REG_DEBUG_CAUSE 8'h15
`define REG_CAUSE_DATA 8'h16
`define REG_STOP_MASK 8'h18
`define REG_SCRATCH_BASE 8'h20
`define REG_BREAK_ADDR_BASE 8'h30
`define REG_BREAK_CTRL_BASE 8'h40

// Group sizes; the scratch and breakpoint base numbers keep these low bits clear.
`define SCRATCH_COUNT 8
`define SCRATCH_IDX_W 3
`define BREAK_COUNT 4
`define BREAK_IDX_W 2
`define OSC_COUNT 4

// Field masks and positions.
`define OSC_COUNT_W 16
`define MEMORY_SIZE_MASK 32'hFFFFFFFC
`define SAVED_STATUS_WMASK 32'h000006DF
`define SAVED_STATUS_MASK 32'h000007DF
`define FETCH_THREAD_MASK 32'h000000FF
`define FETCH_REGISTER_MASK 32'h0000001F
`define DEBUG_CAUSE_MASK 32'h0003FF07
`define STOP_MASK_MASK 32'h000000FF
`define BREAK_CTRL_MASK 32'h00FF0003
`define BREAK_CTRL_ENABLE 0
`define BREAK_CTRL_NOT_EQUAL 1
`define BREAK_CTRL_THREAD_LSB 16
`define BREAK_CTRL_THREAD_MSB 23

// Debug cause codes.
`define CAUSE_NONE 3'h0
`define CAUSE_HOST 3'h1
`define CAUSE_DEBUG_CALL 3'h2
`define CAUSE_CODE_BREAK 3'h3
`define CAUSE_DATA_WATCH 3'h4
`define CAUSE_RESOURCE_WATCH 3'h5

// Default RAM size in bytes; a plain value.
`define MEMORY_SIZE_BYTES 32'h00040000

`endif

/* File: verilog/debug_status_register_bank.v */
// Processor-status register bank for one tile: oscillator counters, RAM
// size, debug entry state, fetch operands, stop mask, scratch words and
// instruction breakpoints.
// Assumes all inputs except ring_osc come from logic on ref_clk, and that
// the core pulses debug_enter once per entry with the entry data valid.
`include "debug_status_defines.vh"

module debug_status_register_bank (
    // Clock and resets.
    input wire ref_clk,
    input wire sys_rst,
    input wire power_on_rst,
    // Processor-status register port.
    input wire [7:0] ps_addr,
    input wire ps_write,
    input wire ps_read,
    input wire [31:0] ps_wdata,
    output reg [31:0] ps_rdata,
    // Tile configuration port onto the scratch words.
    input wire [2:0] cfg_scratch_addr,
    input wire cfg_scratch_write,
    input wire [31:0] cfg_scratch_wdata,
    output reg [31:0] cfg_scratch_rdata,
    // Core state.
    input wire debug_mode,
    input wire current_issue_mode,
    // Debugger entry capture.
    input wire debug_enter,
    input wire [10:0] entry_status,
    input wire [31:0] entry_pc,
    input wire [31:0] entry_sp,
    input wire [2:0] entry_cause,
    input wire [7:0] entry_thread,
    input wire [1:0] entry_watch_num,
    input wire [31:0] entry_data,
    // Instruction stream for breakpoint matching.
    input wire pc_valid,
    input wire [31:0] program_counter,
    input wire [2:0] pc_thread,
    output reg break_request,
    output reg [1:0] break_number,
    output reg [2:0] break_thread,
    // Register fetch selection and thread stop.
    output wire [7:0] fetch_thread,
    output wire [4:0] fetch_register,
    output wire [7:0] thread_stop,
    // Ring oscillators and their run controls.
    input wire [3:0] ring_osc,
    input wire osc_core_run,
    input wire osc_periph_run
);

    // Returns 1 when an address falls in an aligned group of registers.
    function in_group;
        input [7:0] addr;
        input [7:0] base;
        input [7:0] count;
        begin
            in_group = (addr >= base) && (addr < base + count);
        end
    endfunction

    reg [31:0] saved_status;
    reg [31:0] saved_counter;
    reg [31:0] saved_stack;
    reg [31:0] fetch_thread_select;
    reg [31:0] fetch_register_select;
    reg [31:0] debug_cause;
    reg [31:0] cause_data;
    reg [31:0] stop_mask;
    reg [31:0] scratch [0:`SCRATCH_COUNT-1];
    reg [31:0] break_address [0:`BREAK_COUNT-1];
    reg [31:0] break_control [0:`BREAK_COUNT-1];
    reg [`OSC_COUNT_W-1:0] osc_count [0:`OSC_COUNT-1];
    reg [3:0] osc_meta;
    reg [3:0] osc_sync;
    reg [3:0] osc_last;
    reg [31:0] next_rdata;
    reg [`BREAK_COUNT-1:0] break_hit;
    reg [1:0] next_break_number;
    wire debug_write;
    wire [3:0] osc_run;
    integer i;

    // Debug-writable fields only take writes while the core is halted.
    assign debug_write = ps_write && debug_mode;
    assign fetch_thread = fetch_thread_select[7:0];
    assign fetch_register = fetch_register_select[4:0];
    // The mask only bites once the core has left debug mode.
    assign thread_stop = debug_mode ? 8'h00 : stop_mask[7:0];
    assign osc_run = {osc_periph_run, osc_periph_run,
                      osc_core_run, osc_core_run};

    // Oscillators run on their own; sample twice before counting edges.
    // A wide counter clocked by the oscillator would need a crossing, and
    // the limit is that oscillators faster than half ref_clk undercount.
    always @(posedge ref_clk) begin
        osc_meta <= ring_osc;
        osc_sync <= osc_meta;
        osc_last <= osc_sync;
    end

    // Counters clear only on power-on, never on system reset.
    genvar g;
    generate
        for (g = 0; g < `OSC_COUNT; g = g + 1) begin : osc_counter
            always @(posedge ref_clk) begin
                if (power_on_rst) begin
                    osc_count[g] <= {`OSC_COUNT_W{1'b0}};
                end else if (osc_run[g] && osc_sync[g] && !osc_last[g]) begin
                    osc_count[g] <= osc_count[g] + 1'b1;
                end
            end
        end
    endgenerate

    // Breakpoint comparators, one per slot with its own control word.
    generate
        for (g = 0; g < `BREAK_COUNT; g = g + 1) begin : break_match
            always @* begin
                break_hit[g] = pc_valid && !debug_mode
                    && break_control[g][`BREAK_CTRL_ENABLE]
                    && break_control[g][`BREAK_CTRL_THREAD_LSB + pc_thread]
                    && ((program_counter == break_address[g])
                        ^ break_control[g][`BREAK_CTRL_NOT_EQUAL]);
            end
        end
    endgenerate

    // Lowest-numbered breakpoint wins when several fire together.
    always @* begin
        next_break_number = 2'h0;
        for (i = `BREAK_COUNT - 1; i >= 0; i = i - 1) begin
            if (break_hit[i]) begin
                next_break_number = i[1:0];
            end
        end
    end

    // Break request and its details are flopped for the core.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            break_request <= 1'b0;
            break_number <= 2'h0;
            break_thread <= 3'h0;
        end else begin
            break_request <= |break_hit;
            if (|break_hit) begin
                break_number <= next_break_number;
                break_thread <= pc_thread;
            end
        end
    end

    // Debug entry state; capture wins over a write in the same cycle.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            saved_status <= 32'h00000000;
            saved_counter <= 32'h00000000;
            saved_stack <= 32'h00000000;
            debug_cause <= 32'h00000000;
            cause_data <= 32'h00000000;
        end else if (debug_enter) begin
            // Bits 0..4, 6, 7, 9 and 10 carry the thread's saved status word.
            saved_status <= {21'h000000, entry_status}
                            & `SAVED_STATUS_WMASK;
            saved_counter <= entry_pc;
            saved_stack <= entry_sp;
            debug_cause[2:0] <= entry_cause;
            debug_cause[15:8] <= (entry_cause == `CAUSE_HOST)
                                 ? 8'h00 : entry_thread;
            if (entry_cause == `CAUSE_CODE_BREAK) begin
                debug_cause[17:16] <= break_number;
            end else if (entry_cause == `CAUSE_DATA_WATCH
                         || entry_cause == `CAUSE_RESOURCE_WATCH) begin
                debug_cause[17:16] <= entry_watch_num;
            end else begin
                debug_cause[17:16] <= 2'h0;
            end
            if (entry_cause == `CAUSE_DATA_WATCH
                || entry_cause == `CAUSE_RESOURCE_WATCH) begin
                cause_data <= entry_data;
            end
        end else if (debug_write) begin
            case (ps_addr)
                `REG_SAVED_STATUS: begin
                    saved_status <= ps_wdata & `SAVED_STATUS_WMASK;
                end
                `REG_SAVED_COUNTER: begin
                    saved_counter <= ps_wdata;
                end
                `REG_SAVED_STACK: begin
                    saved_stack <= ps_wdata;
                end
                `REG_DEBUG_CAUSE: begin
                    debug_cause <= ps_wdata & `DEBUG_CAUSE_MASK;
                end
                `REG_CAUSE_DATA: begin
                    cause_data <= ps_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Fetch operands, stop mask and breakpoint registers.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            fetch_thread_select <= 32'h00000000;
            fetch_register_select <= 32'h00000000;
            stop_mask <= 32'h00000000;
            for (i = 0; i < `BREAK_COUNT; i = i + 1) begin
                break_address[i] <= 32'h00000000;
                break_control[i] <= 32'h00000000;
            end
        end else if (debug_write) begin
            if (ps_addr == `REG_FETCH_THREAD) begin
                fetch_thread_select <= ps_wdata & `FETCH_THREAD_MASK;
            end
            if (ps_addr == `REG_FETCH_REGISTER) begin
                fetch_register_select <= ps_wdata & `FETCH_REGISTER_MASK;
            end
            if (ps_addr == `REG_STOP_MASK) begin
                stop_mask <= ps_wdata & `STOP_MASK_MASK;
            end
            if (in_group(ps_addr, `REG_BREAK_ADDR_BASE, `BREAK_COUNT)) begin
                break_address[ps_addr[`BREAK_IDX_W-1:0]] <= ps_wdata;
            end
            if (in_group(ps_addr, `REG_BREAK_CTRL_BASE, `BREAK_COUNT)) begin
                break_control[ps_addr[`BREAK_IDX_W-1:0]] <=
                    ps_wdata & `BREAK_CTRL_MASK;
            end
        end
    end

    // Scratch words; a configuration write beats a status-port write
    // to the same word because the external debugger owns the exchange.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            for (i = 0; i < `SCRATCH_COUNT; i = i + 1) begin
                scratch[i] <= 32'h00000000;
            end
        end else begin
            if (debug_write
                && in_group(ps_addr, `REG_SCRATCH_BASE, `SCRATCH_COUNT)) begin
                scratch[ps_addr[`SCRATCH_IDX_W-1:0]] <= ps_wdata;
            end
            if (cfg_scratch_write) begin
                scratch[cfg_scratch_addr] <= cfg_scratch_wdata;
            end
        end
    end

    // Read decode; unmapped numbers and reserved bits read zero.
    always @* begin
        next_rdata = 32'h00000000;
        case (ps_addr)
            `REG_TILE_CELL_OSC: next_rdata = {16'h0000, osc_count[0]};
            `REG_TILE_WIRE_OSC: next_rdata = {16'h0000, osc_count[1]};
            `REG_PERIPH_CELL_OSC: next_rdata = {16'h0000, osc_count[2]};
            `REG_PERIPH_WIRE_OSC: next_rdata = {16'h0000, osc_count[3]};
            `REG_MEMORY_SIZE: begin
                next_rdata = `MEMORY_SIZE_BYTES & `MEMORY_SIZE_MASK;
            end
            `REG_SAVED_STATUS: begin
                // Issue mode bit shows the live core, not a stored value.
                next_rdata = (saved_status & `SAVED_STATUS_WMASK)
                             | {23'h000000, current_issue_mode,
                                8'h00};
            end
            `REG_SAVED_COUNTER: next_rdata = saved_counter;
            `REG_SAVED_STACK: next_rdata = saved_stack;
            `REG_FETCH_THREAD: next_rdata = fetch_thread_select;
            `REG_FETCH_REGISTER: next_rdata = fetch_register_select;
            `REG_DEBUG_CAUSE: next_rdata = debug_cause;
            `REG_CAUSE_DATA: next_rdata = cause_data;
            `REG_STOP_MASK: next_rdata = stop_mask;
            default: begin
                if (in_group(ps_addr, `REG_SCRATCH_BASE, `SCRATCH_COUNT)) begin
                    next_rdata = scratch[ps_addr[`SCRATCH_IDX_W-1:0]];
                end else if (in_group(ps_addr, `REG_BREAK_ADDR_BASE,
                                      `BREAK_COUNT)) begin
                    next_rdata = break_address[ps_addr[`BREAK_IDX_W-1:0]];
                end else if (in_group(ps_addr, `REG_BREAK_CTRL_BASE,
                                      `BREAK_COUNT)) begin
                    next_rdata = break_control[ps_addr[`BREAK_IDX_W-1:0]];
                end
            end
        endcase
    end

    // Status-port read data is flopped and held until the next read; scratch read data is flopped every cycle.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ps_rdata <= 32'h00000000;
            cfg_scratch_rdata <= 32'h00000000;
        end else begin
            if (ps_read) begin
                ps_rdata <= next_rdata;
            end
            cfg_scratch_rdata <= scratch[cfg_scratch_addr];
        end
    end

endmodule

/* File: verif/debug_status_register_bank_sva.sv */
// Port checks for the debug status register bank.
// Assumes one clock and a synchronous active-high system reset.
`include "debug_status_defines.vh"
module debug_status_checker (
    // Clock and reset.
    input wire ref_clk,
    input wire sys_rst,
    // Register port.
    input wire [7:0] ps_addr,
    input wire ps_write,
    input wire ps_read,
    input wire [31:0] ps_wdata,
    input wire [31:0] ps_rdata,
    // Scratch port.
    input wire [2:0] cfg_scratch_addr,
    input wire cfg_scratch_write,
    input wire [31:0] cfg_scratch_wdata,
    input wire [31:0] cfg_scratch_rdata,
    // Core state and breakpoints.
    input wire debug_mode,
    input wire current_issue_mode,
    input wire pc_valid,
    input wire break_request,
    input wire [7:0] fetch_thread,
    input wire [4:0] fetch_register,
    input wire [7:0] thread_stop
);
    // Everything lives in the one clock domain.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    chk_stop_debug: assert property (debug_mode |-> thread_stop == 8'h00)
        else $error("thread stop not released in debug mode");
    chk_fetch_thread: assert property ((ps_write && debug_mode &&
        ps_addr == 8'h13) |=> fetch_thread == $past(ps_wdata[7:0]))
        else $error("fetch thread does not follow write");
    chk_fetch_reg: assert property ((ps_write && debug_mode &&
        ps_addr == 8'h14) |=> fetch_register == $past(ps_wdata[4:0]))
        else $error("fetch register does not follow write");
    chk_break_cause: assert property (break_request |->
        $past(pc_valid) && !$past(debug_mode))
        else $error("break without an issued instruction");
    chk_status_live: assert property ((ps_read && ps_addr == 8'h10) |=>
        ps_rdata[8] == $past(current_issue_mode) && ps_rdata[31:11] == 0)
        else $error("status issue-mode bit not live");
    chk_scratch_cfg: assert property (cfg_scratch_write ##1 (!ps_write &&
        !cfg_scratch_write && $stable(cfg_scratch_addr)) |=>
        cfg_scratch_rdata == $past(cfg_scratch_wdata, 2))
        else $error("scratch word lost its configuration write");
    chk_unmapped_zero: assert property ((ps_read && ps_addr == 8'h01) |=>
        ps_rdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_memory_size: assert property ((ps_read && ps_addr == 8'h0C) |=>
        ps_rdata == (`MEMORY_SIZE_BYTES & `MEMORY_SIZE_MASK))
        else $error("memory size read wrong");
    chk_osc_upper: assert property ((ps_read && ps_addr >= 8'h07 &&
        ps_addr <= 8'h0A) |=> ps_rdata[31:16] == 16'h0000)
        else $error("oscillator upper bits not zero");
endmodule

bind debug_status_register_bank debug_status_checker chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .ps_addr(ps_addr), .ps_write(ps_write),
    .ps_read(ps_read), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
    .cfg_scratch_addr(cfg_scratch_addr), .cfg_scratch_write(cfg_scratch_write),
    .cfg_scratch_wdata(cfg_scratch_wdata),
    .cfg_scratch_rdata(cfg_scratch_rdata), .debug_mode(debug_mode),
    .current_issue_mode(current_issue_mode), .pc_valid(pc_valid),
    .break_request(break_request), .fetch_thread(fetch_thread),
    .fetch_register(fetch_register), .thread_stop(thread_stop));

/* File: verif/debug_host_model.sv */
// External debugger on the tile configuration scratch port.
// Assumes callers enter its tasks just after a rising clock edge.
module debug_host_model (
    // Clock.
    input wire ref_clk,
    // Scratch port.
    output logic [2:0] cfg_scratch_addr,
    output logic cfg_scratch_write,
    output logic [31:0] cfg_scratch_wdata,
    input wire [31:0] cfg_scratch_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cfg_scratch_addr = 3'h0;
    initial cfg_scratch_write = 1'b0;
    initial cfg_scratch_wdata = 32'h00000000;

    // One write; data is scrambled afterwards so stale values cannot help.
    task automatic put(logic [2:0] idx, logic [31:0] d);
        cfg_scratch_addr = idx;
        cfg_scratch_wdata = d;
        cfg_scratch_write = 1'b1;
        @(posedge ref_clk);
        #1 cfg_scratch_write = 1'b0;
        cfg_scratch_wdata = ~d;
        @(posedge ref_clk);
        #1;
    endtask

    // The read data trails the address by one edge.
    task automatic get(logic [2:0] idx, output logic [31:0] d);
        cfg_scratch_addr = idx;
        @(posedge ref_clk);
        #1 d = cfg_scratch_rdata;
    endtask
endmodule

/* File: verif/test_debug_status_register_bank.sv */
// Self-checking bench for the debug status register bank.
// Assumes the defines header is on the include path.
`include "debug_status_defines.vh"
module test_debug_status_register_bank;
    timeunit 1ns;
    timeprecision 100ps;
    // Design inputs, all given values at time zero.
    logic ref_clk = 0, sys_rst = 1, power_on_rst = 0, ps_write = 0;
    logic ps_read = 0, debug_mode = 0, current_issue_mode = 0;
    logic debug_enter = 0, pc_valid = 0, osc_core_run = 0;
    logic osc_periph_run = 0;
    logic [7:0] ps_addr = 0, entry_thread = 0;
    logic [31:0] ps_wdata = 0, entry_pc = 0, entry_sp = 0, entry_data = 0;
    logic [31:0] program_counter = 0, rv, ps_rdata, cfg_scratch_wdata;
    logic [31:0] cfg_scratch_rdata;
    logic [10:0] entry_status = 0;
    logic [2:0] entry_cause = 0, pc_thread = 0, cfg_scratch_addr, break_thread;
    logic [1:0] entry_watch_num = 0, break_number;
    logic [3:0] ring_osc = 0;
    logic cfg_scratch_write, break_request;
    logic [7:0] fetch_thread, thread_stop;
    logic [4:0] fetch_register;
    int mismatches = 0, checks_done = 0, cycles = 0;

    debug_status_register_bank dut (.ref_clk, .sys_rst, .power_on_rst,
        .ps_addr, .ps_write, .ps_read, .ps_wdata, .ps_rdata,
        .cfg_scratch_addr, .cfg_scratch_write, .cfg_scratch_wdata,
        .cfg_scratch_rdata, .debug_mode, .current_issue_mode, .debug_enter,
        .entry_status, .entry_pc, .entry_sp, .entry_cause, .entry_thread,
        .entry_watch_num, .entry_data, .pc_valid, .program_counter,
        .pc_thread, .break_request, .break_number, .break_thread,
        .fetch_thread, .fetch_register, .thread_stop, .ring_osc,
        .osc_core_run, .osc_periph_run);
    debug_host_model host (.ref_clk, .cfg_scratch_addr, .cfg_scratch_write,
        .cfg_scratch_wdata, .cfg_scratch_rdata);

    // 4 ns clock; the cycle ceiling cuts a hang far beyond the real run.
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every driver starts 1 ns after an edge and leaves a quiet edge behind.
    task automatic tick(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        ps_addr = a;
        ps_wdata = d;
        ps_write = 1;
        tick();
        ps_write = 0;
        ps_wdata = ~d;
        tick();
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        ps_addr = a;
        ps_read = 1;
        tick();
        ps_read = 0;
        check(what, ps_rdata, exp);
        tick();
    endtask
    task automatic enter(logic [2:0] c, logic [7:0] t, logic [1:0] w);
        debug_enter = 1;
        entry_cause = c;
        entry_thread = t;
        entry_watch_num = w;
        entry_data = {24'hC0DE00, t};
        tick();
        debug_enter = 0;
        tick();
    endtask
    task automatic issue(logic [31:0] pc, logic [2:0] t, logic rq,
        logic [1:0] n);
        pc_valid = 1;
        program_counter = pc;
        pc_thread = t;
        tick();
        pc_valid = 0;
        check("break request", break_request, rq);
        if (rq)
            check("break number", break_number, n);
        tick();
    endtask

    // Read-write fields keep only their defined bits; others are guarded.
    task automatic t_regs();
        logic [7:0] ra [7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h18, 8'h27, 8'h32};
        logic [31:0] rm [7] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF, 32'h1F,
            32'hFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
        rd(8'h15, 32'h0, "cause after reset");
        rd(8'h01, 32'h0, "unmapped");
        debug_mode = 1;
        for (int i = 0; i < 7; i++) begin
            wr(ra[i], 32'hC3A55AF7);
            rd(ra[i], 32'hC3A55AF7 & rm[i], "field");
        end
        check("fetch thread", fetch_thread, 8'hF7);
        check("fetch register", fetch_register, 5'h17);
        check("stop in debug", thread_stop, 8'h00);
        wr(8'h0C, 32'h0);
        rd(8'h0C, `MEMORY_SIZE_BYTES & `MEMORY_SIZE_MASK, "ram size");
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h6DF, "status");
        current_issue_mode = 1;
        rd(8'h10, 32'h7DF, "status live");
        debug_mode = 0;
        wr(8'h11, 32'h0);
        rd(8'h11, 32'hC3A55AF7, "guarded write");
        check("stop outside debug", thread_stop, 8'hF7);
    endtask

    // Host, call, data and resource cause codes, their thread and watch fields.
    task automatic t_entry();
        debug_mode = 1;
        current_issue_mode = 0;
        entry_status = 11'h255;
        entry_pc = 32'h12345678;
        entry_sp = 32'h0003FFF0;
        enter(3'h1, 8'h05, 2'h3);
        rd(8'h15, 32'h1, "host cause");
        rd(8'h10, 32'h255, "status");
        rd(8'h11, 32'h12345678, "pc");
        rd(8'h12, 32'h0003FFF0, "sp");
        enter(3'h2, 8'h03, 2'h3);
        rd(8'h15, 32'h0302, "call cause");
        enter(3'h4, 8'h06, 2'h2);
        rd(8'h15, 32'h00020604, "data cause");
        rd(8'h16, 32'hC0DE0006, "watch address");
        enter(3'h5, 8'h07, 2'h1);
        rd(8'h15, 32'h00010705, "resource cause");
        rd(8'h16, 32'hC0DE0007, "resource id");
    endtask

    // Slots 1 and 3 match equal, slot 0 matches not-equal, all on thread 2.
    task automatic t_breaks();
        debug_mode = 1;
        wr(8'h30, 32'h00001000);
        wr(8'h31, 32'h00001000);
        wr(8'h33, 32'h00001000);
        wr(8'h40, 32'h00040003);
        wr(8'h41, 32'h00040001);
        wr(8'h43, 32'h00040001);
        issue(32'h00001000, 3'h2, 1'b0, 2'h0);
        debug_mode = 0;
        issue(32'h00001000, 3'h2, 1'b1, 2'h1);
        check("break thread", break_thread, 3'h2);
        issue(32'h00001000, 3'h3, 1'b0, 2'h0);
        issue(32'h00002000, 3'h2, 1'b1, 2'h0);
        issue(32'h00001000, 3'h2, 1'b1, 2'h1);
        debug_mode = 1;
        enter(3'h3, 8'h02, 2'h0);
        rd(8'h15, 32'h00010203, "break cause");
    endtask

    // Both ports reach the same scratch words: word 2 written by the host, word 5 by the status port.
    task automatic t_scratch();
        host.put(3'h2, 32'h9E3779B9);
        rd(8'h22, 32'h9E3779B9, "scratch from cfg");
        wr(8'h25, 32'h7F4A7C15);
        host.get(3'h5, rv);
        check("scratch from ps", rv, 32'h7F4A7C15);
    endtask

    // Five edges on every oscillator; only the core pair is running.
    task automatic t_osc();
        power_on_rst = 1;
        tick();
        power_on_rst = 0;
        osc_core_run = 1;
        repeat (5) begin
            ring_osc = 4'hF;
            tick(3);
            ring_osc = 4'h0;
            tick(3);
        end
        tick(4);
        osc_core_run = 0;
        tick(10);
        for (int i = 0; i < 4; i++)
            rd(8'(8'h07 + i), i < 2 ? 32'h5 : 32'h0, "osc count");
        sys_rst = 1;
        tick(2);
        sys_rst = 0;
        for (int i = 0; i < 4; i++)
            rd(8'(8'h07 + i), i < 2 ? 32'h5 : 32'h0, "osc kept");
        // Now only the peripheral pair runs, for two edges.
        osc_periph_run = 1;
        repeat (2) begin
            ring_osc = 4'hF;
            tick(3);
            ring_osc = 4'h0;
            tick(3);
        end
        tick(4);
        osc_periph_run = 0;
        tick(10);
        for (int i = 0; i < 4; i++)
            rd(8'(8'h07 + i), i < 2 ? 32'h5 : 32'h2, "osc periph");
    endtask

    initial begin
        tick(6);
        sys_rst = 0;
        t_regs();
        t_entry();
        t_breaks();
        t_scratch();
        t_osc();
        print_verdict();
    end
endmodule
